// ---- cbs_pkg.sv ----
// shared constants and types for the charger boost and status register bank
package cbs_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] CBS_ADDR_TOP_CTRL   = 8'h00;
  localparam logic [7:0] CBS_ADDR_BOOST_CTRL = 8'h04;
  localparam logic [7:0] CBS_ADDR_OP_STATUS  = 8'h05;
  localparam logic [7:0] CBS_ADDR_FAULT_STAT = 8'h06;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] CBS_BOOST_CTRL_RST = 8'h42;
  localparam logic [7:0] CBS_STATUS_RST     = 8'h00;
  localparam int unsigned CBS_BIT_SOFT_RST  = 7;
  localparam int unsigned CBS_BIT_VB2       = 7;
  localparam int unsigned CBS_BIT_VB1       = 6;
  localparam int unsigned CBS_BIT_VB0       = 5;
  localparam int unsigned CBS_BIT_BOOST_EN  = 4;
  localparam int unsigned CBS_BIT_SWITCH_EN = 3;
  localparam int unsigned CBS_BIT_DSC_EN    = 2;
  localparam int unsigned CBS_BIT_DET_EN    = 1;

  // ==========================================================
  // boost target in millivolts
  localparam logic [12:0] CBS_BOOST_BASE_MV = 13'h1450;
  localparam logic [12:0] CBS_BOOST_VB2_MV  = 13'h0064;
  localparam logic [12:0] CBS_BOOST_VB1_MV  = 13'h0032;
  localparam logic [12:0] CBS_BOOST_VB0_MV  = 13'h0019;

  // ==========================================================
  // serial port
  localparam logic [3:0] CBS_BYTE_BITS      = 4'h8;
  // arbitrary bus address, not tied to any product
  localparam logic [6:0] CBS_DEV_ADDR_DFLT  = 7'h2A;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CBS_OP_IDLE       = 2'b00,
    CBS_OP_CHARGE     = 2'b01,
    CBS_OP_BOOST      = 2'b10,
    CBS_OP_PATH_CHG   = 2'b11
  } cbs_op_t;

  typedef enum logic [1:0] {
    CBS_DET_OFF       = 2'b00,
    CBS_DET_WAIT_RISE = 2'b01,
    CBS_DET_ARMED     = 2'b10,
    CBS_DET_HELD      = 2'b11
  } cbs_det_t;

  typedef enum logic [2:0] {
    CBS_I2C_IDLE   = 3'b000,
    CBS_I2C_DEV    = 3'b001,
    CBS_I2C_DEVACK = 3'b010,
    CBS_I2C_WR     = 3'b011,
    CBS_I2C_WRACK  = 3'b100,
    CBS_I2C_RD     = 3'b101,
    CBS_I2C_RDACK  = 3'b110
  } cbs_i2c_t;

  typedef struct packed {
    logic       vin_below_boost_max;
    logic       vin_above_present;
    logic       sys_above_arm;
    logic       sys_below_trip;
    logic       batt_uv;
    logic       batt_recharged;
    logic       output_short_flag;
    logic       boost_ilim;
    logic       vin_loop;
    logic       iin_loop;
    cbs_op_t    core_state;
    logic [1:0] charge_phase;
    logic [1:0] charge_fault;
    logic [2:0] temp_zone;
  } cbs_pins_t;

endpackage : cbs_pkg

// ---- cbs_det_if.sv ----
// carrier between the register bank and the attach detector
`timescale 1ns/1ps
interface cbs_det_if;
  logic enable;
  logic sys_above_arm;
  logic sys_below_trip;
  logic clear_req;
  logic soft_reset;
  logic flag;

  modport det (
    input  enable,
    input  sys_above_arm,
    input  sys_below_trip,
    input  clear_req,
    input  soft_reset,
    output flag
  );

  modport bank (
    output enable,
    output sys_above_arm,
    output sys_below_trip,
    output clear_req,
    output soft_reset,
    input  flag
  );
endinterface : cbs_det_if

// ---- cbs_attach_det.sv ----
// attach detector watching the output node against battery fractions
`timescale 1ns/1ps
module cbs_attach_det (
  input  wire logic  i_ref_clk,
  input  wire logic  i_reset,
  cbs_det_if.det     det
);
  import cbs_pkg::*;

  typedef struct packed {
    cbs_det_t st;
    logic     flag;
  } cbs_det_state_t;

  cbs_det_state_t state_reg;
  cbs_det_state_t state_next;

  // ==========================================================
  // detection sequence
  always_comb begin
    state_next = state_reg;
    if (det.clear_req) begin
      state_next.flag = 1'b0;
    end
    case (state_reg.st)
      CBS_DET_OFF: begin
        if (det.enable) begin
          state_next.st = CBS_DET_WAIT_RISE;
        end
      end
      CBS_DET_WAIT_RISE: begin
        if (det.sys_above_arm) begin
          state_next.st = CBS_DET_ARMED;
        end
      end
      CBS_DET_ARMED: begin
        if (det.sys_below_trip) begin
          // set wins over a clear in the same cycle
          state_next.flag = 1'b1;
          state_next.st   = CBS_DET_HELD;
        end
      end
      CBS_DET_HELD: begin
        // next round only after software cleared the flag
        if (!state_reg.flag) begin
          state_next.st = CBS_DET_WAIT_RISE;
        end
      end
      default: begin
        state_next.st = CBS_DET_OFF;
      end
    endcase
    if (!det.enable) begin
      state_next.st = CBS_DET_OFF;
    end
    if (det.soft_reset) begin
      state_next.st   = CBS_DET_OFF;
      state_next.flag = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= '{st: CBS_DET_OFF, flag: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign det.flag = state_reg.flag;

endmodule : cbs_attach_det

// ---- cbs_charger_regs.sv ----
// serial-port register bank for boost control and charger status
// Functional notes
// - boost target is 5.2V minus 100mV, minus 50mV, plus 25mV per set bit
// - boost starts from its enable bit only while input is below 2V
// - output discharge path follows its enable bit
// - attach detection runs only while enabled; host toggles it to restart
// - detection arms once output node rises to 90% of battery
// - armed detection sets the attach flag when output falls to 75%
// - writing one clears the attach flag; writing zero keeps it
// - operating state field: idle, charge, boost, power path with charge
// - input present bit follows input above 3.45V
// - any change of operating status raises the interrupt
// - any change of fault status raises the interrupt
// - battery undervoltage flag latches, clears when battery recharged or on register reset
// - output short flag follows short detection
// - boost current limit flag while boost runs in switch current limit
// - charge fault code: normal, input under, input over, timer expired
// - writing register reset bit restores defaults and self-clears
`timescale 1ns/1ps
module cbs_charger_regs #(
  parameter logic [6:0] DEV_ADDR = cbs_pkg::CBS_DEV_ADDR_DFLT
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_reset,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  output logic               o_sda,
  output logic               o_sda_oe,
  input  wire logic          i_vin_below_boost_max,
  input  wire logic          i_vin_above_present,
  input  wire logic          i_sys_above_arm,
  input  wire logic          i_sys_below_trip,
  input  wire logic          i_batt_uv,
  input  wire logic          i_batt_recharged,
  input  wire logic          i_output_short_flag,
  input  wire logic          i_boost_ilim,
  input  wire logic          i_vin_loop,
  input  wire logic          i_iin_loop,
  input  wire cbs_pkg::cbs_op_t i_core_state,
  input  wire logic [1:0]    i_charge_phase,
  input  wire logic [1:0]    i_charge_fault,
  input  wire logic [2:0]    i_temp_zone,
  output logic [12:0]        o_boost_target_mv,
  output logic               o_boost_run,
  output logic               o_output_switch_on,
  output logic               o_output_discharge_on,
  output logic               o_int
);
  import cbs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    cbs_pins_t   pin_s1;
    cbs_pins_t   pin_s2;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    cbs_i2c_t    i2c_st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        is_read;
    logic [7:0]  ptr;
    logic        have_ptr;
    logic        sda_oe;
    logic        soft_rst;
    logic        det_clear;
    logic [7:1]  boost_ctrl;
    logic        boost_active;
    logic        batt_uv_flag;
    logic [7:0]  op_prev;
    logic [7:0]  fault_prev;
    logic        irq;
    logic [12:0] boost_mv;
  } cbs_bank_state_t;

  cbs_bank_state_t state_reg;
  cbs_bank_state_t state_next;
  cbs_pins_t       pins_raw;
  cbs_pins_t       pins;
  logic [7:0]      op_status;
  logic [7:0]      fault_status;
  cbs_det_if       det_bus ();

  // ==========================================================
  // helpers
  function automatic logic [12:0] boost_mv_calc(input logic [7:1] ctrl);
    logic [12:0] mv;
    mv = CBS_BOOST_BASE_MV;
    if (ctrl[CBS_BIT_VB2]) begin
      mv = mv - CBS_BOOST_VB2_MV;
    end
    if (ctrl[CBS_BIT_VB1]) begin
      mv = mv - CBS_BOOST_VB1_MV;
    end
    if (ctrl[CBS_BIT_VB0]) begin
      mv = mv + CBS_BOOST_VB0_MV;
    end
    return mv;
  endfunction : boost_mv_calc

  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:1] ctrl,
                                           input logic flag, input logic [7:0] op,
                                           input logic [7:0] flt);
    logic [7:0] d;
    d = 8'h00;
    case (addr)
      CBS_ADDR_BOOST_CTRL: d = {ctrl, flag};
      CBS_ADDR_OP_STATUS:  d = op;
      CBS_ADDR_FAULT_STAT: d = flt;
      default:             d = 8'h00;
    endcase
    return d;
  endfunction : read_byte

  // ==========================================================
  // status assembly
  always_comb begin
    pins_raw = '{
      vin_below_boost_max: i_vin_below_boost_max,
      vin_above_present:   i_vin_above_present,
      sys_above_arm:       i_sys_above_arm,
      sys_below_trip:      i_sys_below_trip,
      batt_uv:             i_batt_uv,
      batt_recharged:      i_batt_recharged,
      output_short_flag:           i_output_short_flag,
      boost_ilim:          i_boost_ilim,
      vin_loop:            i_vin_loop,
      iin_loop:            i_iin_loop,
      core_state:          i_core_state,
      charge_phase:        i_charge_phase,
      charge_fault:        i_charge_fault,
      temp_zone:           i_temp_zone
    };
  end

  assign pins = state_reg.pin_s2;

  always_comb begin
    op_status = {
      (state_reg.boost_active ? CBS_OP_BOOST : pins.core_state),
      pins.charge_phase,
      pins.vin_loop,
      pins.iin_loop,
      pins.vin_above_present,
      1'b0
    };
    fault_status = {
      state_reg.batt_uv_flag,
      pins.output_short_flag,
      pins.boost_ilim & state_reg.boost_active,
      pins.charge_fault,
      pins.temp_zone
    };
  end

  // ==========================================================
  // next state
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       wr_en;
    logic [7:0] rdata;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    wr_en    = 1'b0;
    rdata    = 8'h00;
    state_next = state_reg;

    // first stage feeds only the second
    state_next.pin_s1 = pins_raw;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.scl_s1 = i_scl;
    state_next.scl_s2 = state_reg.scl_s1;
    state_next.scl_d  = state_reg.scl_s2;
    state_next.sda_s1 = i_sda;
    state_next.sda_s2 = state_reg.sda_s1;
    state_next.sda_d  = state_reg.sda_s2;
    state_next.soft_rst  = 1'b0;
    state_next.det_clear = 1'b0;

    scl_rise = state_reg.scl_s2 & ~state_reg.scl_d;
    scl_fall = ~state_reg.scl_s2 & state_reg.scl_d;
    start_c  = state_reg.scl_s2 & state_reg.scl_d & state_reg.sda_d & ~state_reg.sda_s2;
    stop_c   = state_reg.scl_s2 & state_reg.scl_d & ~state_reg.sda_d & state_reg.sda_s2;
    rdata    = read_byte(state_reg.ptr, state_reg.boost_ctrl, det_bus.flag, op_status, fault_status);

    // serial slave: bytes after the pointer auto-increment it
    if (start_c) begin
      state_next.i2c_st   = CBS_I2C_DEV;
      state_next.bitcnt   = 4'h0;
      state_next.have_ptr = 1'b0;
      state_next.sda_oe   = 1'b0;
    end else if (stop_c) begin
      state_next.i2c_st = CBS_I2C_IDLE;
      state_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (state_reg.i2c_st)
        CBS_I2C_DEV, CBS_I2C_WR: begin
          state_next.shreg  = {state_reg.shreg[6:0], state_reg.sda_s2};
          state_next.bitcnt = state_reg.bitcnt + 4'h1;
        end
        CBS_I2C_RDACK: begin
          if (state_reg.sda_s2) begin
            state_next.i2c_st = CBS_I2C_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_reg.i2c_st)
        CBS_I2C_DEV: begin
          if (state_reg.bitcnt == CBS_BYTE_BITS) begin
            if (state_reg.shreg[7:1] == DEV_ADDR) begin
              state_next.sda_oe  = 1'b1;
              state_next.is_read = state_reg.shreg[0];
              state_next.i2c_st  = CBS_I2C_DEVACK;
            end else begin
              state_next.i2c_st = CBS_I2C_IDLE;
            end
          end
        end
        CBS_I2C_DEVACK: begin
          if (state_reg.is_read) begin
            state_next.shreg  = rdata;
            state_next.sda_oe = ~rdata[7];
            state_next.bitcnt = 4'h1;
            state_next.i2c_st = CBS_I2C_RD;
          end else begin
            state_next.sda_oe = 1'b0;
            state_next.bitcnt = 4'h0;
            state_next.i2c_st = CBS_I2C_WR;
          end
        end
        CBS_I2C_WR: begin
          if (state_reg.bitcnt == CBS_BYTE_BITS) begin
            state_next.sda_oe = 1'b1;
            state_next.i2c_st = CBS_I2C_WRACK;
            if (!state_reg.have_ptr) begin
              state_next.ptr      = state_reg.shreg;
              state_next.have_ptr = 1'b1;
            end else begin
              wr_en         = 1'b1;
              state_next.ptr = state_reg.ptr + 8'h01;
            end
          end
        end
        CBS_I2C_WRACK: begin
          state_next.sda_oe = 1'b0;
          state_next.bitcnt = 4'h0;
          state_next.i2c_st = CBS_I2C_WR;
        end
        CBS_I2C_RD: begin
          if (state_reg.bitcnt == CBS_BYTE_BITS) begin
            state_next.sda_oe = 1'b0;
            state_next.ptr    = state_reg.ptr + 8'h01;
            state_next.i2c_st = CBS_I2C_RDACK;
          end else begin
            state_next.sda_oe = ~state_reg.shreg[6];
            state_next.shreg  = {state_reg.shreg[6:0], 1'b0};
            state_next.bitcnt = state_reg.bitcnt + 4'h1;
          end
        end
        CBS_I2C_RDACK: begin
          state_next.shreg  = rdata;
          state_next.sda_oe = ~rdata[7];
          state_next.bitcnt = 4'h1;
          state_next.i2c_st = CBS_I2C_RD;
        end
        default: begin
          state_next.i2c_st = CBS_I2C_IDLE;
        end
      endcase
    end

    // register writes; status registers ignore writes
    if (wr_en) begin
      case (state_reg.ptr)
        CBS_ADDR_TOP_CTRL: begin
          state_next.soft_rst = state_reg.shreg[CBS_BIT_SOFT_RST];
        end
        CBS_ADDR_BOOST_CTRL: begin
          state_next.boost_ctrl = state_reg.shreg[7:1];
          state_next.det_clear  = state_reg.shreg[0];
        end
        default: begin
        end
      endcase
    end

    // boost only starts with input low; once running it stays until disabled
    if (!state_reg.boost_ctrl[CBS_BIT_BOOST_EN]) begin
      state_next.boost_active = 1'b0;
    end else if (!state_reg.boost_active && pins.vin_below_boost_max) begin
      state_next.boost_active = 1'b1;
    end

    // recharge clears, new undervoltage wins
    if (pins.batt_recharged) begin
      state_next.batt_uv_flag = 1'b0;
    end
    if (pins.batt_uv) begin
      state_next.batt_uv_flag = 1'b1;
    end

    // change detect against last sampled image
    state_next.op_prev    = op_status;
    state_next.fault_prev = fault_status;
    state_next.irq = (op_status != state_reg.op_prev)
                   | (fault_status != state_reg.fault_prev);

    // reset bit is a pulse; address 0x00 is not decoded for reads, so it reads back as zero
    if (state_reg.soft_rst) begin
      state_next.boost_ctrl   = CBS_BOOST_CTRL_RST[7:1];
      state_next.boost_active = 1'b0;
      state_next.batt_uv_flag = 1'b0;
    end
    state_next.boost_mv = boost_mv_calc(state_next.boost_ctrl);
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= '{
        pin_s1:       '0,
        pin_s2:       '0,
        scl_s1:       1'b1,
        scl_s2:       1'b1,
        scl_d:        1'b1,
        sda_s1:       1'b1,
        sda_s2:       1'b1,
        sda_d:        1'b1,
        i2c_st:       CBS_I2C_IDLE,
        bitcnt:       4'h0,
        shreg:        8'h00,
        is_read:      1'b0,
        ptr:          8'h00,
        have_ptr:     1'b0,
        sda_oe:       1'b0,
        soft_rst:     1'b0,
        det_clear:    1'b0,
        boost_ctrl:   CBS_BOOST_CTRL_RST[7:1],
        boost_active: 1'b0,
        batt_uv_flag: 1'b0,
        op_prev:      CBS_STATUS_RST,
        fault_prev:   CBS_STATUS_RST,
        irq:          1'b0,
        boost_mv:     boost_mv_calc(CBS_BOOST_CTRL_RST[7:1])
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // detector hookup
  assign det_bus.enable         = state_reg.boost_ctrl[CBS_BIT_DET_EN];
  assign det_bus.sys_above_arm  = pins.sys_above_arm;
  assign det_bus.sys_below_trip = pins.sys_below_trip;
  assign det_bus.clear_req      = state_reg.det_clear;
  assign det_bus.soft_reset     = state_reg.soft_rst;

  cbs_attach_det u_attach_det (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .det       (det_bus)
  );

  // ==========================================================
  // outputs
  assign o_sda                 = 1'b0;
  assign o_sda_oe              = state_reg.sda_oe;
  assign o_boost_target_mv     = state_reg.boost_mv;
  assign o_boost_run           = state_reg.boost_active;
  assign o_output_switch_on    = state_reg.boost_ctrl[CBS_BIT_SWITCH_EN];
  assign o_output_discharge_on = state_reg.boost_ctrl[CBS_BIT_DSC_EN];
  assign o_int                 = state_reg.irq;

endmodule : cbs_charger_regs

// ---- cbs_regs_asserts.sv ----
// checker for the charger register bank ports
`timescale 1ns/1ps
module cbs_regs_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_scl,
  input wire logic        i_vin_below_boost_max,
  input wire logic        i_output_short_flag,
  input wire logic [1:0]  i_charge_phase,
  input wire logic [2:0]  i_temp_zone,
  input wire logic [12:0] o_boost_target_mv,
  input wire logic        o_boost_run,
  input wire logic        o_output_switch_on,
  input wire logic        o_output_discharge_on,
  input wire logic        o_int
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // ========================================
  // checks
  a_int_short: assert property ($changed(i_output_short_flag) |-> ##[2:4] o_int)
    else $error("no interrupt after short change");
  a_int_temp: assert property ($changed(i_temp_zone) |-> ##[2:4] o_int)
    else $error("no interrupt after zone change");
  a_int_phase: assert property ($changed(i_charge_phase) |-> ##[2:4] o_int)
    else $error("no interrupt after phase change");
  a_target_legal: assert property (
    o_boost_target_mv inside {[13'h13BA:13'h1469]} && o_boost_target_mv % 25 == 0)
    else $error("boost target off grid");
  a_reset_dflt: assert property (
    $fell(i_reset) |-> o_boost_target_mv == 13'h141E && !o_boost_run && !o_output_switch_on)
    else $error("outputs not at defaults");
  a_boost_gate: assert property ($rose(o_boost_run) |-> $past(i_vin_below_boost_max, 3))
    else $error("boost started with input high");
  // writes land while the serial clock is low
  a_dsc_write: assert property ($changed(o_output_discharge_on) |-> !i_scl)
    else $error("discharge moved outside a write");
  a_switch_write: assert property ($changed(o_output_switch_on) |-> !i_scl)
    else $error("switch moved outside a write");
endmodule : cbs_regs_asserts
bind cbs_charger_regs cbs_regs_asserts i_chk (.*);

// ---- cbs_host_model.sv ----
// serial host model for the register bank
`timescale 1ns/1ps
module cbs_host_model #(
  parameter logic [6:0] DEV = 7'h2A
) (
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ========================================
  // bus phases, slow so the synchronisers keep up
  task automatic hb;
    repeat (8) @(negedge i_ref_clk);
  endtask : hb
  task automatic bit_x(input logic b, output logic r);
    repeat (2) @(negedge i_ref_clk);
    o_sda_low = !b;
    hb();
    o_scl = 1'b1;
    hb();
    r = i_sda;
    o_scl = 1'b0;
  endtask : bit_x
  task automatic edge_x(input logic f);
    repeat (2) @(negedge i_ref_clk);
    o_sda_low = !f;
    hb();
    o_scl = 1'b1;
    hb();
    o_sda_low = f;
    hb();
    o_scl = !f;
  endtask : edge_x
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(last, nak);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    edge_x(1'b1);
    xfer({DEV, 1'b0}, 1'b1, q, n0);
    xfer(a, 1'b1, q, n1);
    xfer(d, 1'b1, q, n2);
    edge_x(1'b0);
    nak = n0 | n1 | n2;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    edge_x(1'b1);
    xfer({DEV, 1'b0}, 1'b1, q, n0);
    xfer(a, 1'b1, q, n1);
    edge_x(1'b1);
    xfer({DEV, 1'b1}, 1'b1, q, n2);
    xfer(8'hFF, 1'b1, d, n3);
    edge_x(1'b0);
    nak = n0 | n1 | n2;
  endtask : rd
endmodule : cbs_host_model

// ---- test_charger_boost_status_regs.sv ----
// testbench for the charger register bank
`timescale 1ns/1ps
module test_charger_boost_status_regs;
  import cbs_pkg::*;
  logic clk, rst, scl, h_low, sda_w, sda_o, sda_oe, run, sw, dsc, irq, nk;
  logic vb, vp, arm, trip, uv, rch, sh, il, vl, cl;
  cbs_op_t     cs;
  logic [1:0]  ph, cf;
  logic [2:0]  tz;
  logic [12:0] mv;
  logic [7:0]  rv;
  int n_mismatch, n_tests, cyc, nint;
  int seed = 32'h03BBB8DE;
  // released line floats high through the pull-up
  assign sda_w = !h_low && !(sda_oe && !sda_o);
  cbs_charger_regs i_dut (.i_ref_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_o),
    .o_sda_oe(sda_oe), .i_vin_below_boost_max(vb), .i_vin_above_present(vp), .i_sys_above_arm(arm),
    .i_sys_below_trip(trip), .i_batt_uv(uv), .i_batt_recharged(rch), .i_output_short_flag(sh), .i_boost_ilim(il),
    .i_vin_loop(vl), .i_iin_loop(cl), .i_core_state(cs), .i_charge_phase(ph), .i_charge_fault(cf),
    .i_temp_zone(tz), .o_boost_target_mv(mv), .o_boost_run(run), .o_output_switch_on(sw),
    .o_output_discharge_on(dsc), .o_int(irq));
  cbs_host_model #(.DEV(CBS_DEV_ADDR_DFLT)) i_host (.i_ref_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(h_low));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) nint++;
    if (cyc == 90000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ========================================
  // helpers
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rv, nk);
    chk(rv, e);
    chk(nk, 1'b0);
  endtask : rchk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d, nk);
    chk(nk, 1'b0);
  endtask : wreg
  function automatic logic [12:0] mv_of(input logic [2:0] v);
    return 13'h1450 - (v[2] ? 13'h0064 : 13'h0000) - (v[1] ? 13'h0032 : 13'h0000) + (v[0] ? 13'h0019 : 13'h0000);
  endfunction : mv_of
  task automatic give_verdict;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ========================================
  // sequence
  initial begin
    logic [7:0]  d;
    logic [15:0] pv, nv;
    logic [12:0] r;
    {vb, vp, arm, trip, uv, rch, sh, il, vl, cl, ph, cf, tz} = '0;
    cs = CBS_OP_IDLE;
    rst = 1'b1;
    w(10);
    rst = 1'b0;
    w(5);
    chk(mv, 13'h141E);
    rchk(8'h04, 8'h42);
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h00);
    for (int k = 0; k < 8; k++) begin
      r = 13'($random(seed));
      d = {3'(k), 1'b0, r[3:2], 2'b11};
      wreg(8'h04, d);
      w(2);
      chk(mv, mv_of(3'(k)));
      chk({sw, dsc}, d[3:2]);
      rchk(8'h04, {d[7:1], 1'b0});
    end
    wreg(8'h04, 8'h52);
    il = 1'b1;
    w(6);
    chk(run, 1'b0);
    vb = 1'b1;
    w(6);
    chk(run, 1'b1);
    rchk(8'h05, 8'h80);
    rchk(8'h06, 8'h20);
    vb = 1'b0;
    wreg(8'h04, 8'h42);
    il = 1'b0;
    w(2);
    chk(run, 1'b0);
    w(8);
    pv = '0;
    for (int k = 0; k < 6; k++) begin
      r = (k == 0) ? 13'h0000 : 13'($random(seed));
      cs = cbs_op_t'((r[1:0] == 2'b10) ? 2'b11 : r[1:0]);
      {sh, vp, cl, vl, ph, cf} = r[9:2];
      tz = r[12] ? 3'h4 : {1'b0, r[11:10]};
      nv = {cs, ph, vl, cl, vp, 1'b0, 1'b0, sh, 1'b0, cf, tz};
      nint = 0;
      w(8);
      chk(16'(nint), (nv != pv) ? 16'h0001 : 16'h0000);
      rchk(8'h05, nv[15:8]);
      rchk(8'h06, nv[7:0]);
      pv = nv;
    end
    {vp, cl, vl, ph, sh, cf, tz} = '0;
    cs = CBS_OP_IDLE;
    wreg(8'h06, 8'hFF);
    uv = 1'b1;
    w(4);
    uv = 1'b0;
    rchk(8'h06, 8'h80);
    rchk(8'h06, 8'h80);
    rch = 1'b1;
    w(4);
    rch = 1'b0;
    rchk(8'h06, 8'h00);
    // trip without a prior rise must not flag
    trip = 1'b1;
    w(6);
    rchk(8'h04, 8'h42);
    trip = 1'b0;
    arm = 1'b1;
    w(6);
    arm = 1'b0;
    trip = 1'b1;
    w(6);
    rchk(8'h04, 8'h43);
    wreg(8'h04, 8'h42);
    rchk(8'h04, 8'h43);
    wreg(8'h04, 8'h43);
    rchk(8'h04, 8'h42);
    wreg(8'h04, 8'h40);
    arm = 1'b1;
    w(6);
    arm = 1'b0;
    w(6);
    rchk(8'h04, 8'h40);
    wreg(8'h04, 8'h42);
    arm = 1'b1;
    w(6);
    arm = 1'b0;
    w(6);
    rchk(8'h04, 8'h43);
    wreg(8'h04, 8'h1D);
    wreg(8'h00, 8'h80);
    w(2);
    chk({sw, dsc}, 2'b00);
    rchk(8'h04, 8'h42);
    rchk(8'h00, 8'h00);
    give_verdict();
  end
endmodule : test_charger_boost_status_regs
